// ---- hw/twu_regs.vh ----
`ifndef TWU_REGS_VH
`define TWU_REGS_VH
// Register byte offsets
`define TWU_OFF_DATA 8'h00
`define TWU_OFF_STAT 8'h04
`define TWU_OFF_ADDR 8'h08
`define TWU_OFF_CTRL 8'h0c
// control_reg field positions
`define TWU_C_DONE 7
`define TWU_C_ACK 6
`define TWU_C_BEG 5
`define TWU_C_END 4
`define TWU_C_WCOL 3
`define TWU_C_EN 2
`define TWU_C_IRQ 0
// Reset values
`define TWU_DATA_RST 8'hff
`define TWU_ADDR_RST 8'h00
`define TWU_CODE_RST 8'hf8
// Status codes, prescaler bits zero
`define TWU_S_START 8'h08
`define TWU_S_RSTART 8'h10
`define TWU_S_MT_AACK 8'h18
`define TWU_S_MT_ANAK 8'h20
`define TWU_S_MT_DACK 8'h28
`define TWU_S_MT_DNAK 8'h30
`define TWU_S_ARB 8'h38
`define TWU_S_MR_AACK 8'h40
`define TWU_S_MR_ANAK 8'h48
`define TWU_S_MR_DACK 8'h50
`define TWU_S_MR_DNAK 8'h58
`define TWU_S_SR_AACK 8'h60
`define TWU_S_SR_ARB 8'h68
`define TWU_S_SR_GC 8'h70
`define TWU_S_SR_ARBGC 8'h78
`define TWU_S_SR_DACK 8'h80
`define TWU_S_SR_DNAK 8'h88
`define TWU_S_SR_GDACK 8'h90
`define TWU_S_SR_GDNAK 8'h98
`define TWU_S_SR_STOP 8'ha0
// Timing
`define TWU_CLK_PS 5000
`define TWU_SCL_HALF_NS 80
`endif

// ---- hw/twu_sync.v ----
`timescale 1ns/10ps
`default_nettype none
module twu_sync (
   input  wire       clk,
   input  wire       rstn,
   input  wire [1:0] line_i,
   output wire [1:0] line_s,
   output wire       scl_rise,
   output wire       scl_fall,
   output wire       start_det,
   output wire       stop_det
);
   // Bit 1 is SCL, bit 0 is SDA; an idle bus reads high
   wire [1:0] prev;
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : g_line
         reg s1_q;
         reg s2_q;
         reg pv_q;
         always @(posedge clk or negedge rstn)
         begin
            if (!rstn)
            begin
               s1_q <= 1'b1;
               s2_q <= 1'b1;
               pv_q <= 1'b1;
            end
            else
            begin
               s1_q <= line_i[g];
               s2_q <= s1_q;
               pv_q <= s2_q;
            end
         end
         assign line_s[g] = s2_q;
         assign prev[g]   = pv_q;
      end
   endgenerate
   assign scl_rise  = line_s[1] & ~prev[1];
   assign scl_fall  = ~line_s[1] & prev[1];
   assign start_det = line_s[1] & prev[1] & prev[0] & ~line_s[0];
   assign stop_det  = line_s[1] & prev[1] & ~prev[0] & line_s[0];
endmodule // twu_sync
`default_nettype wire

// ---- hw/twu_shift.v ----
`timescale 1ns/10ps
`default_nettype none
module twu_shift (
   input  wire       clk,
   input  wire       rstn,
   input  wire       scl_rise,
   input  wire       scl_fall,
   input  wire       start_det,
   input  wire       sda_s,
   output reg  [7:0] byte_q,
   output reg        nak_q,
   output reg        fall8_q,
   output reg        end9_q
);
   // Watches every byte on the bus, including the ones this unit sends
   reg [3:0] cnt_q;
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt_q   <= 4'h0;
         byte_q  <= 8'hff;
         nak_q   <= 1'b1;
         fall8_q <= 1'b0;
         end9_q  <= 1'b0;
      end
      else
      begin
         fall8_q <= scl_fall & (cnt_q == 4'h8);
         end9_q  <= scl_fall & (cnt_q == 4'h9);
         if (start_det)
            cnt_q <= 4'h0;
         else if (scl_rise)
         begin
            if (cnt_q == 4'h8)
            begin
               nak_q <= sda_s;
               cnt_q <= 4'h9;
            end
            else
            begin
               byte_q <= {byte_q[6:0], sda_s};
               cnt_q  <= (cnt_q == 4'h9) ? 4'h1 : cnt_q + 4'h1;
            end
         end
      end
   end
endmodule // twu_shift
`default_nettype wire

// ---- hw/twu_top.v ----
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "twu_regs.vh"
// Functional notes
// - At 0x08 software loads read address and clears flag; device sends it, samples ack.
// - At 0x10 read address keeps receiving; write address switches to master transmitter.
// - At 0x38 bus released, not-addressed slave; begin bit restarts once bus free.
// - At 0x40 next byte is received; returned ack follows ack_enable_bit.
// - At 0x48 begin gives repeated start, end a stop, both stop then start.
// - At 0x50 byte is readable; next byte received, ack per ack_enable_bit.
// - At 0x58 begin, end or both act as at 0x48; stop clears end bit.
// - Upper seven own_address_reg bits are the address; bit 0 enables general call.
// - When addressed, direction bit 0 selects slave receiver, else slave transmitter; the code only acks an own address with direction bit 0.
// - Own address with write bit sets job_done_flag and a valid status code.
// - Lost arbitration then addressed reports 0x68 own address, 0x78 general call.
// - Cleared ack_enable_bit answers the next received data byte with not-acknowledge.
// - With ack_enable_bit zero own address is ignored but bus is still watched.
// - In deep sleep an address match wakes the part; SCL held until flag cleared.
// - job_done_flag clears by writing one; clearing lets the transfer go on.
// - After deep sleep wake the data register need not hold the last bus byte.
// - A requested start is generated only once the bus is free.
module twu_top (
   input  wire        clk,
   input  wire        rstn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata_q,
   output reg         pready_q,
   output reg         pslverr_q,
   input  wire        scl_i,
   output reg         scl_o_q,
   output reg         scl_oe_n_q,
   input  wire        sda_i,
   output reg         sda_o_q,
   output reg         sda_oe_n_q,
   input  wire        sleep_deep,
   output reg         wake_req_q
);
   localparam integer HALF_I = (`TWU_SCL_HALF_NS * 1000) / `TWU_CLK_PS;
   localparam [7:0] HALF = HALF_I[7:0];
   localparam [7:0] QTR  = {1'b0, HALF_I[7:1]};
   localparam [5:0] S_IDLE  = 6'b000001;
   localparam [5:0] S_START = 6'b000010;
   localparam [5:0] S_RSTRT = 6'b000100;
   localparam [5:0] S_BIT   = 6'b001000;
   localparam [5:0] S_STOP  = 6'b010000;
   localparam [5:0] S_HOLD  = 6'b100000;

   wire [1:0] line_s;
   wire       scl_s = line_s[1];
   wire       sda_s = line_s[0];
   wire       scl_rise;
   wire       scl_fall;
   wire       start_det;
   wire       stop_det;
   wire [7:0] rx_byte;
   wire       rx_nak;
   wire       fall8;
   wire       end9;

   twu_sync u_sync (
      .clk       (clk),
      .rstn      (rstn),
      .line_i    ({scl_i, sda_i}),
      .line_s    (line_s),
      .scl_rise  (scl_rise),
      .scl_fall  (scl_fall),
      .start_det (start_det),
      .stop_det  (stop_det)
   );

   twu_shift u_shift (
      .clk       (clk),
      .rstn      (rstn),
      .scl_rise  (scl_rise),
      .scl_fall  (scl_fall),
      .start_det (start_det),
      .sda_s     (sda_s),
      .byte_q    (rx_byte),
      .nak_q     (rx_nak),
      .fall8_q   (fall8),
      .end9_q    (end9)
   );

   // Software-visible state
   reg [7:0] data_q;
   reg [7:0] code_q;
   reg [7:0] own_q;
   reg [1:0] psc_q;
   reg       done_q;
   reg       acken_q;
   reg       beg_q;
   reg       end_q;
   reg       wcol_q;
   reg       en_q;
   reg       irqen_q;
   // Master engine
   reg [5:0] st_q;
   reg [1:0] ph_q;
   reg [7:0] tmr_q;
   reg [3:0] mbit_q;
   reg [7:0] sh_q;
   reg       m_scl_q;
   reg       m_sda_q;
   reg       m_tx_q;
   reg       m_addr_q;
   reg       m_ack_q;
   reg       rep_q;
   reg       own_bus_q;
   reg       arb_q;
   reg       m_evt_q;
   reg       m_ld_q;
   reg       m_stop_q;
   reg [7:0] m_code_q;
   // Slave side
   reg       s_act_q;
   reg       s_gc_q;
   reg       s_sda_q;
   reg       addr_ph_q;
   reg       busy_q;
   reg       s_evt_q;
   reg       s_ld_q;
   reg [7:0] s_code_q;

   wire tmr_zero = (tmr_q == 8'h00);
   wire m_bit    = (mbit_q == 4'h8) ? (m_tx_q ? 1'b0 : acken_q) : (m_tx_q & ~sh_q[7]);
   wire lost     = scl_rise & ~m_sda_q & ~sda_s & (m_tx_q ? (mbit_q != 4'h8) : (mbit_q == 4'h8));
   wire match_gc = (rx_byte[7:1] == 7'h00) & own_q[0];
   wire match    = (rx_byte[7:1] == own_q[7:1]) | match_gc;
   wire may_ack  = en_q & acken_q & ~rx_byte[0] & match & ~own_bus_q;

   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_q      <= S_IDLE;
         ph_q      <= 2'h0;
         tmr_q     <= 8'h00;
         mbit_q    <= 4'h0;
         sh_q      <= 8'h00;
         m_scl_q   <= 1'b0;
         m_sda_q   <= 1'b0;
         m_tx_q    <= 1'b1;
         m_addr_q  <= 1'b0;
         m_ack_q   <= 1'b0;
         rep_q     <= 1'b0;
         own_bus_q <= 1'b0;
         arb_q     <= 1'b0;
         m_evt_q   <= 1'b0;
         m_ld_q    <= 1'b0;
         m_stop_q  <= 1'b0;
         m_code_q  <= `TWU_CODE_RST;
      end
      else
      begin
         m_evt_q  <= 1'b0;
         m_ld_q   <= 1'b0;
         m_stop_q <= 1'b0;
         if (!tmr_zero)
            tmr_q <= tmr_q - 8'h01;
         if (end9)
            arb_q <= 1'b0;
         case (st_q)
            S_IDLE:
            begin
               m_scl_q <= 1'b0;
               m_sda_q <= 1'b0;
               ph_q    <= 2'h0;
               if (en_q && beg_q && !done_q && !busy_q && !s_act_q)
                  st_q <= S_START;
            end
            S_START:
            begin
               if (ph_q == 2'h0)
               begin
                  m_sda_q   <= 1'b1;
                  own_bus_q <= 1'b1;
                  tmr_q     <= HALF;
                  ph_q      <= 2'h1;
               end
               else if (tmr_zero)
               begin
                  m_scl_q  <= 1'b1;
                  m_code_q <= rep_q ? `TWU_S_RSTART : `TWU_S_START;
                  m_evt_q  <= 1'b1;
                  m_addr_q <= 1'b1;
                  m_tx_q   <= 1'b1;
                  st_q     <= S_HOLD;
               end
            end
            S_RSTRT:
            begin
               if (ph_q == 2'h0)
               begin
                  m_sda_q <= 1'b0;
                  tmr_q   <= HALF;
                  ph_q    <= 2'h1;
               end
               else if (ph_q == 2'h1 && tmr_zero)
               begin
                  m_scl_q <= 1'b0;
                  ph_q    <= 2'h2;
               end
               else if (ph_q == 2'h2)
               begin
                  // Waits out any stretching by the slave
                  if (!scl_s)
                     tmr_q <= HALF;
                  else if (tmr_zero)
                  begin
                     rep_q <= 1'b1;
                     ph_q  <= 2'h0;
                     st_q  <= S_START;
                  end
               end
            end
            S_BIT:
            begin
               if (ph_q == 2'h0 && tmr_zero)
               begin
                  m_sda_q <= m_bit;
                  tmr_q   <= HALF;
                  ph_q    <= 2'h1;
               end
               else if (ph_q == 2'h1 && tmr_zero)
               begin
                  m_scl_q <= 1'b0;
                  ph_q    <= 2'h2;
               end
               else if (ph_q == 2'h2)
               begin
                  if (lost)
                  begin
                     arb_q     <= 1'b1;
                     own_bus_q <= 1'b0;
                     m_sda_q   <= 1'b0;
                     st_q      <= S_IDLE;
                  end
                  else if (!scl_s)
                     tmr_q <= HALF;
                  else
                  begin
                     if (scl_rise && mbit_q == 4'h8)
                        m_ack_q <= ~sda_s;
                     if (tmr_zero)
                     begin
                        m_scl_q <= 1'b1;
                        tmr_q   <= QTR;
                        ph_q    <= 2'h0;
                        sh_q    <= {sh_q[6:0], 1'b0};
                        mbit_q  <= mbit_q + 4'h1;
                        if (mbit_q == 4'h8)
                        begin
                           mbit_q   <= 4'h0;
                           m_sda_q  <= 1'b0;
                           m_evt_q  <= 1'b1;
                           m_addr_q <= 1'b0;
                           st_q     <= S_HOLD;
                           if (m_addr_q)
                           begin
                              m_tx_q <= ~data_q[0];
                              if (data_q[0])
                                 m_code_q <= m_ack_q ? `TWU_S_MR_AACK : `TWU_S_MR_ANAK;
                              else
                                 m_code_q <= m_ack_q ? `TWU_S_MT_AACK : `TWU_S_MT_ANAK;
                           end
                           else if (m_tx_q)
                              m_code_q <= m_ack_q ? `TWU_S_MT_DACK : `TWU_S_MT_DNAK;
                           else
                           begin
                              m_code_q <= m_sda_q ? `TWU_S_MR_DACK : `TWU_S_MR_DNAK;
                              m_ld_q   <= 1'b1;
                           end
                        end
                     end
                  end
               end
            end
            S_HOLD:
            begin
               // Flag lands one cycle after the event pulse
               if (!done_q && !m_evt_q)
               begin
                  ph_q <= 2'h0;
                  if (end_q)
                     st_q <= S_STOP;
                  else if (beg_q)
                     st_q <= S_RSTRT;
                  else
                  begin
                     sh_q   <= data_q;
                     mbit_q <= 4'h0;
                     st_q   <= S_BIT;
                  end
               end
            end
            S_STOP:
            begin
               if (ph_q == 2'h0 && tmr_zero)
               begin
                  m_sda_q <= 1'b1;
                  tmr_q   <= HALF;
                  ph_q    <= 2'h1;
               end
               else if (ph_q == 2'h1 && tmr_zero)
               begin
                  m_scl_q <= 1'b0;
                  ph_q    <= 2'h2;
               end
               else if (ph_q == 2'h2)
               begin
                  if (!scl_s)
                     tmr_q <= HALF;
                  else if (tmr_zero)
                  begin
                     m_sda_q <= 1'b0;
                     tmr_q   <= HALF;
                     ph_q    <= 2'h3;
                  end
               end
               else if (ph_q == 2'h3 && tmr_zero)
               begin
                  // A begin bit still set gives the start after this stop
                  own_bus_q <= 1'b0;
                  rep_q     <= 1'b0;
                  m_stop_q  <= 1'b1;
                  st_q      <= S_IDLE;
               end
            end
            default:
               st_q <= S_IDLE;
         endcase
      end
   end

   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_act_q    <= 1'b0;
         s_gc_q     <= 1'b0;
         s_sda_q    <= 1'b0;
         addr_ph_q  <= 1'b0;
         busy_q     <= 1'b0;
         s_evt_q    <= 1'b0;
         s_ld_q     <= 1'b0;
         s_code_q   <= `TWU_CODE_RST;
         wake_req_q <= 1'b0;
      end
      else
      begin
         s_evt_q <= 1'b0;
         s_ld_q  <= 1'b0;
         if (start_det)
         begin
            busy_q    <= 1'b1;
            addr_ph_q <= 1'b1;
         end
         if (stop_det)
         begin
            busy_q  <= 1'b0;
            s_act_q <= 1'b0;
            if (s_act_q)
            begin
               s_code_q <= `TWU_S_SR_STOP;
               s_evt_q  <= 1'b1;
            end
         end
         if (fall8)
            s_sda_q <= addr_ph_q ? may_ack : (s_act_q & acken_q);
         if (end9)
         begin
            s_sda_q   <= 1'b0;
            addr_ph_q <= 1'b0;
            if (addr_ph_q && s_sda_q)
            begin
               s_act_q <= 1'b1;
               s_gc_q  <= rx_byte[7:1] == 7'h00;
               s_evt_q <= 1'b1;
               if (rx_byte[7:1] == 7'h00)
                  s_code_q <= arb_q ? `TWU_S_SR_ARBGC : `TWU_S_SR_GC;
               else
                  s_code_q <= arb_q ? `TWU_S_SR_ARB : `TWU_S_SR_AACK;
               if (sleep_deep)
                  wake_req_q <= 1'b1;
            end
            else if (arb_q)
            begin
               s_code_q <= `TWU_S_ARB;
               s_evt_q  <= 1'b1;
            end
            else if (s_act_q && !addr_ph_q)
            begin
               s_evt_q <= 1'b1;
               s_ld_q  <= ~sleep_deep;
               if (!s_sda_q)
                  s_act_q <= 1'b0;
               if (s_gc_q)
                  s_code_q <= s_sda_q ? `TWU_S_SR_GDACK : `TWU_S_SR_GDNAK;
               else
                  s_code_q <= s_sda_q ? `TWU_S_SR_DACK : `TWU_S_SR_DNAK;
            end
         end
         if (!sleep_deep)
            wake_req_q <= 1'b0;
      end
   end

   // APB: one wait state, read data and error latched with pready
   wire       acc    = psel & penable;
   wire       wr_go  = acc & pready_q & pwrite;
   wire       hit    = (paddr == `TWU_OFF_DATA) | (paddr == `TWU_OFF_STAT) |
                       (paddr == `TWU_OFF_ADDR) | (paddr == `TWU_OFF_CTRL);
   reg  [7:0] rd_v;
   always @*
   begin
      case (paddr)
         `TWU_OFF_DATA: rd_v = data_q;
         `TWU_OFF_STAT: rd_v = {code_q[7:3], 1'b0, psc_q};
         `TWU_OFF_ADDR: rd_v = own_q;
         `TWU_OFF_CTRL: rd_v = {done_q, acken_q, beg_q, end_q, wcol_q, en_q, 1'b0, irqen_q};
         default:       rd_v = 8'h00;
      endcase
   end

   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
         data_q    <= `TWU_DATA_RST;
         code_q    <= `TWU_CODE_RST;
         own_q     <= `TWU_ADDR_RST;
         psc_q     <= 2'h0;
         done_q    <= 1'b0;
         acken_q   <= 1'b0;
         beg_q     <= 1'b0;
         end_q     <= 1'b0;
         wcol_q    <= 1'b0;
         en_q      <= 1'b0;
         irqen_q   <= 1'b0;
      end
      else
      begin
         pready_q <= acc & ~pready_q;
         if (acc && !pready_q)
         begin
            prdata_q  <= {24'h000000, rd_v};
            pslverr_q <= ~hit;
         end
         if (m_ld_q || s_ld_q)
            data_q <= rx_byte;
         if (m_stop_q)
            end_q <= 1'b0;
         if (wr_go)
         begin
            case (paddr)
               `TWU_OFF_DATA:
               begin
                  // Data may only change while the unit is parked
                  if (done_q)
                  begin
                     data_q <= pwdata[7:0];
                     wcol_q <= 1'b0;
                  end
                  else
                     wcol_q <= 1'b1;
               end
               `TWU_OFF_STAT: psc_q <= pwdata[1:0];
               `TWU_OFF_ADDR: own_q <= pwdata[7:0];
               `TWU_OFF_CTRL:
               begin
                  acken_q <= pwdata[`TWU_C_ACK];
                  beg_q   <= pwdata[`TWU_C_BEG];
                  end_q   <= pwdata[`TWU_C_END];
                  en_q    <= pwdata[`TWU_C_EN];
                  irqen_q <= pwdata[`TWU_C_IRQ];
                  if (pwdata[`TWU_C_DONE])
                     done_q <= 1'b0;
               end
               default: psc_q <= psc_q;
            endcase
         end
         // A new event beats a clear in the same cycle
         if (m_evt_q || s_evt_q)
         begin
            done_q <= 1'b1;
            code_q <= m_evt_q ? m_code_q : s_code_q;
         end
      end
   end

   // Open-drain pins: enable low pulls the wire low
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         scl_o_q    <= 1'b0;
         sda_o_q    <= 1'b0;
         scl_oe_n_q <= 1'b1;
         sda_oe_n_q <= 1'b1;
      end
      else
      begin
         scl_o_q    <= 1'b0;
         sda_o_q    <= 1'b0;
         scl_oe_n_q <= ~(m_scl_q | (s_act_q & done_q));
         sda_oe_n_q <= ~(m_sda_q | s_sda_q);
      end
   end
endmodule // twu_top
`default_nettype wire

// ---- tb/twu_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module twu_assertions (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata_q,
   input wire logic        pready_q,
   input wire logic        pslverr_q,
   input wire logic        scl_o_q,
   input wire logic        sda_o_q,
   input wire logic        sleep_deep,
   input wire logic        wake_req_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   chk_ready_pulse: assert property (pready_q |=> !pready_q)
      else $error("pready held over one cycle");
   chk_ready_wait: assert property (psel && penable && !pready_q |=> pready_q)
      else $error("access not answered after one wait state");
   chk_ready_idle: assert property (!psel |=> !pready_q)
      else $error("pready without an access");
   chk_err_map: assert property (pready_q |->
      pslverr_q == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c}))
      else $error("error response does not match address map");
   chk_rd_upper: assert property (pready_q && !pwrite |-> prdata_q[31:8] == 24'h0)
      else $error("read data above bit 7 not zero");
   chk_stat_gap: assert property (pready_q && !pwrite && paddr == 8'h04 |->
      !prdata_q[2])
      else $error("status bit 2 not zero");
   chk_od_low: assert property (!scl_o_q && !sda_o_q)
      else $error("open drain data not low");
   chk_wake_clear: assert property (!sleep_deep ##1 !sleep_deep |-> !wake_req_q)
      else $error("wake request outside deep sleep");
endmodule // twu_assertions
`default_nettype wire

// ---- tb/twu_bus_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module twu_bus_model (
   input  wire logic scl_oe_n,
   input  wire logic sda_oe_n,
   output wire logic scl,
   output wire logic sda
);
   logic m_scl = 1'h1;
   logic m_sda = 1'h1;
   // Pull-ups: a released wire reads high
   assign scl = scl_oe_n & m_scl;
   assign sda = sda_oe_n & m_sda;
   task automatic start();
      m_sda = 1'h0;
      #80 m_scl = 1'h0;
      #40;
   endtask
   // Last bit is the ack slot with SDA released
   task automatic byte_out(input logic [7:0] d, output logic ack);
      for (int i = 8; i >= 0; i--)
      begin
         m_sda = (i == 0) ? 1'h1 : d[i-1];
         #40 m_scl = 1'h1;
         // Device may stretch the low phase
         wait (scl);
         #40 ack = sda;
         #40 m_scl = 1'h0;
         #40;
      end
   endtask
   task automatic stop();
      m_sda = 1'h0;
      #40 m_scl = 1'h1;
      wait (scl);
      #40 m_sda = 1'h1;
      #160;
   endtask
   // Slave side: ack the address, then send bytes
   task automatic slv_addr();
      repeat (8) @(negedge scl);
      m_sda = 1'h0;
      @(negedge scl);
   endtask
   task automatic slv_byte(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--)
      begin
         m_sda = d[i];
         @(negedge scl);
      end
      m_sda = 1'h1;
      @(posedge scl) ack = sda;
      @(negedge scl);
   endtask
endmodule // twu_bus_model
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "twu_regs.vh"
module tb;
   logic        clk = 1'h0;
   logic        rstn = 1'h0;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        sleep = 1'h0;
   logic [31:0] q;
   logic        e, a1, a2;
   wire  [31:0] prdata_q;
   wire         pready_q, pslverr_q, scl_o_q, scl_oe_n_q, sda_o_q, sda_oe_n_q, wake_req_q;
   wire         scl, sda;
   int          fail_count = 0;
   int          checks_done = 0;
   always #2.5 clk = ~clk;
   twu_top u_dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_q,
      .pready_q, .pslverr_q, .scl_i(scl), .scl_o_q, .scl_oe_n_q, .sda_i(sda), .sda_o_q,
      .sda_oe_n_q, .sleep_deep(sleep), .wake_req_q);
   twu_bus_model u_bus (.scl_oe_n(scl_oe_n_q), .sda_oe_n(sda_oe_n_q), .scl, .sda);
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do
         @(posedge clk);
      while (pready_q !== 1'h1 && ++n < 20);
      if (n >= 20)
      begin
         fail_count++;
         complete_run();
      end
      q = prdata_q;
      e = pslverr_q;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic waitc(input int b, input logic v);
      int n;
      n = 0;
      do
         apb(1'h0, `TWU_OFF_CTRL, 32'h0);
      while (q[b] !== v && ++n < 500);
      if (n >= 500)
      begin
         fail_count++;
         complete_run();
      end
   endtask
   // Prescaler bits are storage only, so they are masked off
   task automatic stat(input logic [31:0] exp);
      apb(1'h0, `TWU_OFF_STAT, 32'h0);
      chk("status", q & 32'hf8, exp);
   endtask
   task automatic wr_wait(input logic [7:0] a, input logic [31:0] d, input logic [31:0] s);
      apb(1'h1, a, d);
      waitc(`TWU_C_DONE, 1'h1);
      stat(s);
   endtask
   initial
   begin
      #400000 fail_count++;
      complete_run();
   end
   initial
   begin
      repeat (8) @(posedge clk);
      rstn <= 1'h1;
      repeat (4) @(posedge clk);
      stat(32'hf8);
      apb(1'h0, `TWU_OFF_DATA, 32'h0);
      chk("data reset", q, 32'hff);
      apb(1'h0, 8'h10, 32'h0);
      chk("unmapped", {q[30:0], e}, 32'h1);
      $display("test registers done");
      wr_wait(`TWU_OFF_CTRL, 32'ha4, 32'h08);
      fork
         begin
            u_bus.slv_addr();
            u_bus.slv_byte(8'ha5, a1);
            u_bus.slv_byte(8'h3c, a2);
         end
      join_none
      apb(1'h1, `TWU_OFF_DATA, 32'h55);
      wr_wait(`TWU_OFF_CTRL, 32'h84, 32'h40);
      wr_wait(`TWU_OFF_CTRL, 32'hc4, 32'h50);
      apb(1'h0, `TWU_OFF_DATA, 32'h0);
      chk("first byte", q, 32'ha5);
      wr_wait(`TWU_OFF_CTRL, 32'h84, 32'h58);
      apb(1'h0, `TWU_OFF_DATA, 32'h0);
      chk("last byte", q, 32'h3c);
      chk("acks", {a1, a2}, 32'h1);
      apb(1'h1, `TWU_OFF_CTRL, 32'h94);
      waitc(`TWU_C_END, 1'h0);
      $display("test master receive done");
      apb(1'h1, `TWU_OFF_ADDR, 32'h54);
      apb(1'h1, `TWU_OFF_CTRL, 32'h44);
      sleep <= 1'h1;
      u_bus.start();
      u_bus.byte_out(8'h00, a1);
      chk("call ignored", a1, 32'h1);
      u_bus.stop();
      u_bus.start();
      u_bus.byte_out(8'h54, a1);
      chk("own ack", a1, 32'h0);
      waitc(`TWU_C_DONE, 1'h1);
      chk("wake", wake_req_q, 32'h1);
      stat(32'h60);
      chk("scl held", scl_oe_n_q, 32'h0);
      sleep <= 1'h0;
      apb(1'h1, `TWU_OFF_CTRL, 32'hc4);
      chk("wake clear", wake_req_q, 32'h0);
      u_bus.byte_out(8'h77, a1);
      waitc(`TWU_C_DONE, 1'h1);
      stat(32'h80);
      apb(1'h0, `TWU_OFF_DATA, 32'h0);
      chk("slave byte", q, 32'h77);
      apb(1'h1, `TWU_OFF_CTRL, 32'h84);
      u_bus.byte_out(8'h11, a1);
      chk("nack", a1, 32'h1);
      stat(32'h88);
      apb(1'h1, `TWU_OFF_CTRL, 32'hc4);
      u_bus.stop();
      $display("test slave receive done");
      wr_wait(`TWU_OFF_CTRL, 32'ha4, 32'h08);
      apb(1'h1, `TWU_OFF_DATA, 32'h2b);
      wr_wait(`TWU_OFF_CTRL, 32'h84, 32'h48);
      apb(1'h1, `TWU_OFF_CTRL, 32'h94);
      waitc(`TWU_C_END, 1'h0);
      $display("test address refused done");
      complete_run();
   end
endmodule // tb
bind twu_top twu_assertions u_chk (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .prdata_q,
   .pready_q, .pslverr_q, .scl_o_q, .sda_o_q, .sleep_deep, .wake_req_q);
`default_nettype wire
